// ===== rtl/cdb_pkg.sv
// cdb_pkg: shared constants and types of the compliance descriptor link
package cdb_pkg;
  // ************************************************************
  // descriptor layout
  // ************************************************************
  localparam logic [15:0] DESC_TYPE_CRYPTO = 16'h0001;
  localparam logic [31:0] DESC_LEN_CRYPTO  = 32'h0000_0208;
  localparam int          DESC_BYTES       = 528;
  localparam int          HDR_BYTES        = 4;
  localparam int          OFF_LEN          = 4;
  localparam int          OFF_STD          = 8;
  localparam int          OFF_LVL          = 9;
  localparam int          OFF_HW           = 16;
  localparam int          OFF_VER          = 144;
  localparam int          OFF_NAME         = 272;
  localparam int          STR_BYTES        = 16;
  localparam logic [7:0]  STD_140_2        = 8'h32;
  localparam logic [7:0]  STD_140_3        = 8'h33;
  localparam logic [7:0]  ASCII_ONE        = 8'h31;
  // ************************************************************
  // controller registers
  // ************************************************************
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_SID          = 8'h04;
  localparam logic [7:0]  REG_EM           = 8'h08;
  localparam logic [7:0]  REG_BAND         = 8'h0C;
  localparam logic [7:0]  REG_PSID         = 8'h10;
  localparam logic [7:0]  REG_STAT         = 8'h14;
  localparam logic [7:0]  REG_INQLEN       = 8'h18;
  localparam logic [7:0]  REG_INQINFO      = 8'h1C;
  localparam int          CTRL_NB_LSB      = 8;
  localparam logic [1:0]  CMD_PROV         = 2'h1;
  localparam logic [1:0]  CMD_ZERO         = 2'h2;
  localparam logic [1:0]  CMD_INQ          = 2'h3;
  localparam int          STAT_STEP_LSB    = 8;
  // ************************************************************
  // host sequence steps
  // ************************************************************
  localparam logic [4:0]  STEP_PROV        = 5'h00;
  localparam logic [4:0]  STEP_EM_PIN      = 5'h0A;
  localparam logic [4:0]  STEP_BAND_FIRST  = 5'h0B;
  localparam logic [4:0]  STEP_BAND_LAST   = 5'h0D;
  localparam logic [4:0]  STEP_PROV_END    = 5'h0E;
  localparam logic [4:0]  STEP_ZERO        = 5'h0F;
  localparam logic [4:0]  STEP_ZERO_END    = 5'h12;
  localparam logic [4:0]  STEP_INQ         = 5'h13;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NOP, OP_START_ADMIN, OP_START_LOCK, OP_END, OP_GET_MSID, OP_AUTH,
    OP_SET_PIN, OP_MAKERS_OFF, OP_FW_LOCK, OP_FW_LOR, OP_ERASE, OP_REVERT, OP_INQ
  } cdb_op_t;
  typedef enum logic [1:0] {AU_SID, AU_PSID, AU_EM, AU_BM} cdb_auth_t;
  typedef enum logic [1:0] {SS_NONE, SS_ADMIN, SS_LOCK} cdb_sess_t;
  typedef enum logic [2:0] {DS_ZERO, DS_MSID, DS_SID, DS_EM, DS_BAND, DS_PSID} cdb_dsel_t;
  typedef struct packed {
    cdb_op_t   op;
    cdb_auth_t auth;
    cdb_dsel_t dsel;
  } cdb_step_t;
endpackage

// ===== rtl/cdb_link_if.sv
// cdb_link_if: request and answer link between initiator and target
`timescale 1ns/1ps
interface cdb_link_if;
  logic                req_valid;
  logic                req_ready;
  cdb_pkg::cdb_op_t    req_op;
  cdb_pkg::cdb_auth_t  req_auth;
  logic [3:0]          req_band;
  logic [31:0]         req_data;
  logic                rsp_valid;
  logic                rsp_ready;
  logic                rsp_ok;
  logic                rsp_last;
  logic [31:0]         rsp_data;
  modport dev (
    input  req_valid, req_op, req_auth, req_band, req_data, rsp_ready,
    output req_ready, rsp_valid, rsp_ok, rsp_last, rsp_data
  );
  modport host (
    output req_valid, req_op, req_auth, req_band, req_data, rsp_ready,
    input  req_ready, rsp_valid, rsp_ok, rsp_last, rsp_data
  );
endinterface

// ===== rtl/cdb_device.sv
// cdb_device: target end, security state and compliance descriptor framer
// Notes on behaviour
// - type bytes 0-1, reserved 2-3, length 4-7
// - length counts bytes after the length field
// - only type 0001h is ever emitted
// - several same-type descriptors per response allowed
// - specific bytes from 8 chosen by type
// - crypto descriptor: length 0208h, bytes 0-527
// - byte 8: 32h or 33h standard code
// - byte 9 ASCII level; 10-15 reserved
// - bytes 16-143 null-terminated hardware version
// - bytes 144-271 certified version string
// - bytes 272-527 null-terminated module name
// - host opens admin, gets MSID, authenticates SID
// - host sets SID PIN, disables makers, locks port
// - host provisions EraseMaster and each band
// - PSID revert restores factory security defaults
// - four-byte total length header precedes descriptors
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cdb_device #(
  parameter int           NBANDS   = 4,
  parameter int           NDESC    = 1,
  parameter logic [31:0]  MSID     = 32'h1357_2468,  // arbitrary value
  parameter logic [31:0]  PSID     = 32'h9ABC_0F0F,  // arbitrary value
  parameter logic [127:0] HW_STR   = {"HW-A1", 88'h0},
  parameter logic [127:0] VER_STR  = {"FW-1.0", 80'h0},
  parameter logic [127:0] NAME_STR = {"CDB-MOD", 72'h0}
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // link
  cdb_link_if.dev     lnk,
  // user side
  input  wire logic   fips3_sel,
  input  wire logic [1:0] level_sel,
  output logic        makers_enabled,
  output logic        fw_port_locked,
  output logic        fw_lock_on_power,
  output logic [1:0]  session
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {D_IDLE, D_RSP, D_STREAM} cdbd_phase_t;
  typedef struct packed {
    cdbd_phase_t                phase;
    cdb_pkg::cdb_sess_t         sess;
    logic                       authd;
    logic                       em_ok;
    cdb_pkg::cdb_auth_t         who;
    logic [3:0]                 band;
    logic [31:0]                sid_pin;
    logic [31:0]                em_pin;
    logic [NBANDS-1:0][31:0]    band_pin;
    logic                       makers_en;
    logic                       fw_locked;
    logic                       fw_lor;
    logic                       ok;
    logic                       last;
    logic [31:0]                data;
    logic [15:0]                pos;
    logic [9:0]                 off;
  } cdbd_state_t;

  localparam cdbd_state_t RST_S = '{
    phase: D_IDLE, sess: cdb_pkg::SS_NONE, who: cdb_pkg::AU_SID,
    sid_pin: MSID, em_pin: MSID, band_pin: {NBANDS{MSID}},
    makers_en: 1'b1, default: '0
  };
  localparam logic [31:0] TOTAL    = 32'(NDESC * cdb_pkg::DESC_BYTES);
  localparam logic [15:0] LAST_POS = 16'(cdb_pkg::HDR_BYTES + NDESC * cdb_pkg::DESC_BYTES - 1);

  cdbd_state_t q;
  cdbd_state_t d;
  logic        in_admin;
  logic        in_lock;
  logic        band_ok;
  logic        auth_match;
  logic        own_auth;

  // ************************************************************
  // descriptor bytes
  // ************************************************************
  function automatic logic [7:0] str_byte(input logic [127:0] s, input int k);
    if (k < cdb_pkg::STR_BYTES) begin
      return s[8*(cdb_pkg::STR_BYTES-1-k) +: 8];
    end
    return 8'h00;
  endfunction

  function automatic logic [7:0] desc_byte(input int off);
    logic [7:0] b;
    b = 8'h00;
    if (off < 2) begin
      b = cdb_pkg::DESC_TYPE_CRYPTO[8*(1-off) +: 8];
    end else if (off >= cdb_pkg::OFF_LEN && off < cdb_pkg::OFF_STD) begin
      b = cdb_pkg::DESC_LEN_CRYPTO[8*(cdb_pkg::OFF_STD-1-off) +: 8];
    end else if (off == cdb_pkg::OFF_STD) begin
      b = fips3_sel ? cdb_pkg::STD_140_3 : cdb_pkg::STD_140_2;
    end else if (off == cdb_pkg::OFF_LVL) begin
      b = cdb_pkg::ASCII_ONE + {6'h00, level_sel};
    end else if (off >= cdb_pkg::OFF_HW && off < cdb_pkg::OFF_VER) begin
      b = str_byte(HW_STR, off - cdb_pkg::OFF_HW);
    end else if (off >= cdb_pkg::OFF_VER && off < cdb_pkg::OFF_NAME) begin
      b = str_byte(VER_STR, off - cdb_pkg::OFF_VER);
    end else if (off >= cdb_pkg::OFF_NAME && off < cdb_pkg::DESC_BYTES) begin
      b = str_byte(NAME_STR, off - cdb_pkg::OFF_NAME);
    end
    return b;
  endfunction

  function automatic logic [7:0] byte_at(input logic [15:0] pos, input logic [9:0] off);
    if (int'(pos) < cdb_pkg::HDR_BYTES) begin
      return TOTAL[8*(cdb_pkg::HDR_BYTES-1-int'(pos)) +: 8];
    end
    return desc_byte(int'(off));
  endfunction

  // ************************************************************
  // authentication
  // ************************************************************
  assign in_admin = (q.sess == cdb_pkg::SS_ADMIN);
  assign in_lock  = (q.sess == cdb_pkg::SS_LOCK);
  assign band_ok  = (int'(lnk.req_band) < NBANDS);

  always_comb begin
    auth_match = 1'b0;
    case (lnk.req_auth)
      cdb_pkg::AU_SID:  auth_match = in_admin && (lnk.req_data == q.sid_pin);
      cdb_pkg::AU_PSID: auth_match = in_admin && (lnk.req_data == PSID);
      cdb_pkg::AU_EM:   auth_match = in_lock && (lnk.req_data == q.em_pin);
      cdb_pkg::AU_BM:   auth_match = in_lock && band_ok && (lnk.req_data == q.band_pin[lnk.req_band]);
      default:          auth_match = 1'b0;
    endcase
  end

  assign own_auth = q.authd && (q.who == lnk.req_auth) &&
                    (lnk.req_auth != cdb_pkg::AU_BM || q.band == lnk.req_band);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    case (q.phase)
      D_IDLE: begin
        if (lnk.req_valid) begin
          d.phase = D_RSP;
          d.ok    = 1'b0;
          d.last  = 1'b1;
          d.data  = '0;
          case (lnk.req_op)
            cdb_pkg::OP_START_ADMIN: begin
              d.sess  = cdb_pkg::SS_ADMIN;
              d.authd = 1'b0;
              d.ok    = 1'b1;
            end
            cdb_pkg::OP_START_LOCK: begin
              d.sess  = cdb_pkg::SS_LOCK;
              d.authd = 1'b0;
              d.em_ok = 1'b0;
              d.ok    = 1'b1;
            end
            cdb_pkg::OP_END: begin
              d.sess  = cdb_pkg::SS_NONE;
              d.authd = 1'b0;
              d.ok    = 1'b1;
            end
            cdb_pkg::OP_GET_MSID: begin
              d.ok   = (q.sess != cdb_pkg::SS_NONE);
              d.data = d.ok ? MSID : 32'h0000_0000;
            end
            cdb_pkg::OP_AUTH: begin
              d.authd = auth_match;
              d.who   = lnk.req_auth;
              d.em_ok = q.em_ok || (auth_match && lnk.req_auth == cdb_pkg::AU_EM);
              d.band  = lnk.req_band;
              d.ok    = auth_match;
            end
            cdb_pkg::OP_SET_PIN: begin
              if (own_auth && lnk.req_auth != cdb_pkg::AU_PSID) begin
                d.ok = 1'b1;
                case (lnk.req_auth)
                  cdb_pkg::AU_SID: d.sid_pin = lnk.req_data;
                  cdb_pkg::AU_EM:  d.em_pin = lnk.req_data;
                  default:         d.band_pin[lnk.req_band] = lnk.req_data;
                endcase
              end
            end
            cdb_pkg::OP_MAKERS_OFF, cdb_pkg::OP_FW_LOCK, cdb_pkg::OP_FW_LOR: begin
              if (in_admin && q.authd && q.who == cdb_pkg::AU_SID) begin
                d.ok = 1'b1;
                case (lnk.req_op)
                  cdb_pkg::OP_MAKERS_OFF: d.makers_en = 1'b0;
                  cdb_pkg::OP_FW_LOCK:    d.fw_locked = 1'b1;
                  default:                d.fw_lor = 1'b1;
                endcase
              end
            end
            cdb_pkg::OP_ERASE: begin
              if (in_lock && q.em_ok && band_ok) begin
                d.ok = 1'b1;
                d.band_pin[lnk.req_band] = MSID;
              end
            end
            cdb_pkg::OP_REVERT: begin
              if (in_admin && q.authd && q.who == cdb_pkg::AU_PSID) begin
                d = RST_S;
                d.phase = D_RSP;
                d.ok    = 1'b1;
                d.last  = 1'b1;
              end
            end
            cdb_pkg::OP_INQ: begin
              d.phase = D_STREAM;
              d.ok    = 1'b1;
              d.last  = 1'b0;
              d.pos   = '0;
              d.off   = '0;
              d.data  = {24'h000000, byte_at(16'h0000, 10'h000)};
            end
            default: d.ok = 1'b0;
          endcase
        end
      end
      D_RSP: begin
        if (lnk.rsp_ready) begin
          d.phase = D_IDLE;
        end
      end
      D_STREAM: begin
        if (lnk.rsp_ready) begin
          if (q.last) begin
            d.phase = D_IDLE;
          end else begin
            d.pos = q.pos + 16'h0001;
            if (int'(q.pos) < cdb_pkg::HDR_BYTES || int'(q.off) == cdb_pkg::DESC_BYTES - 1) begin
              d.off = '0;
            end else begin
              d.off = q.off + 10'h001;
            end
            d.last = (d.pos == LAST_POS);
            d.data = {24'h000000, byte_at(d.pos, d.off)};
          end
        end
      end
      default: d.phase = D_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign lnk.req_ready    = (q.phase == D_IDLE);
  assign lnk.rsp_valid    = (q.phase != D_IDLE);
  assign lnk.rsp_ok       = q.ok;
  assign lnk.rsp_last     = q.last;
  assign lnk.rsp_data     = q.data;
  assign makers_enabled   = q.makers_en;
  assign fw_port_locked   = q.fw_locked;
  assign fw_lock_on_power = q.fw_lor;
  assign session          = q.sess;
endmodule // cdb_device

// ===== rtl/cdb_host.sv
// cdb_host: initiator end, APB controlled provisioning and zeroization sequencer
`timescale 1ns/1ps
module cdb_host (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  cdb_link_if.host         lnk
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {H_IDLE, H_REQ, H_RSP} cdbh_phase_t;
  typedef struct packed {
    cdbh_phase_t phase;
    logic [4:0]  step;
    logic [3:0]  band;
    logic [3:0]  nbands;
    logic [31:0] sid_new;
    logic [31:0] em_new;
    logic [31:0] band_new;
    logic [31:0] psid;
    logic [31:0] msid;
    logic        done;
    logic        err;
    logic        tamper;
    logic [31:0] inq_len;
    logic [15:0] inq_pos;
    logic [7:0]  inq_std;
    logic [7:0]  inq_lvl;
    logic [31:0] prdata;
  } cdbh_state_t;

  cdbh_state_t        q;
  cdbh_state_t        d;
  cdb_pkg::cdb_step_t st;
  logic               addr_ok;

  // ************************************************************
  // step table
  // ************************************************************
  function automatic cdb_pkg::cdb_step_t step_dec(input logic [4:0] s);
    cdb_pkg::cdb_step_t t;
    t = '{cdb_pkg::OP_NOP, cdb_pkg::AU_SID, cdb_pkg::DS_ZERO};
    case (s)
      5'h00: t.op = cdb_pkg::OP_START_ADMIN;
      5'h01: t.op = cdb_pkg::OP_GET_MSID;
      5'h02: t = '{cdb_pkg::OP_AUTH, cdb_pkg::AU_SID, cdb_pkg::DS_MSID};
      5'h03: t = '{cdb_pkg::OP_SET_PIN, cdb_pkg::AU_SID, cdb_pkg::DS_SID};
      5'h04: t.op = cdb_pkg::OP_MAKERS_OFF;
      5'h05: t.op = cdb_pkg::OP_FW_LOCK;
      5'h06: t.op = cdb_pkg::OP_FW_LOR;
      5'h07: t.op = cdb_pkg::OP_END;
      5'h08: t.op = cdb_pkg::OP_START_LOCK;
      5'h09: t = '{cdb_pkg::OP_AUTH, cdb_pkg::AU_EM, cdb_pkg::DS_MSID};
      5'h0A: t = '{cdb_pkg::OP_SET_PIN, cdb_pkg::AU_EM, cdb_pkg::DS_EM};
      5'h0B: t.op = cdb_pkg::OP_ERASE;
      5'h0C: t = '{cdb_pkg::OP_AUTH, cdb_pkg::AU_BM, cdb_pkg::DS_MSID};
      5'h0D: t = '{cdb_pkg::OP_SET_PIN, cdb_pkg::AU_BM, cdb_pkg::DS_BAND};
      5'h0E: t.op = cdb_pkg::OP_END;
      5'h0F: t.op = cdb_pkg::OP_START_ADMIN;
      5'h10: t = '{cdb_pkg::OP_AUTH, cdb_pkg::AU_PSID, cdb_pkg::DS_PSID};
      5'h11: t.op = cdb_pkg::OP_REVERT;
      5'h12: t.op = cdb_pkg::OP_END;
      5'h13: t.op = cdb_pkg::OP_INQ;
      default: t.op = cdb_pkg::OP_NOP;
    endcase
    return t;
  endfunction

  assign st = step_dec(q.step);
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= cdb_pkg::REG_INQINFO);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        cdb_pkg::REG_CTRL:    d.prdata = {20'h00000, q.nbands, 8'h00};
        cdb_pkg::REG_SID:     d.prdata = q.sid_new;
        cdb_pkg::REG_EM:      d.prdata = q.em_new;
        cdb_pkg::REG_BAND:    d.prdata = q.band_new;
        cdb_pkg::REG_PSID:    d.prdata = q.psid;
        cdb_pkg::REG_STAT:    d.prdata = {19'h00000, q.step, 4'h0, q.tamper, q.err, q.done, q.phase != H_IDLE};
        cdb_pkg::REG_INQLEN:  d.prdata = q.inq_len;
        cdb_pkg::REG_INQINFO: d.prdata = {q.inq_pos, q.inq_lvl, q.inq_std};
        default:              d.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        cdb_pkg::REG_SID:  d.sid_new = pwdata;
        cdb_pkg::REG_EM:   d.em_new = pwdata;
        cdb_pkg::REG_BAND: d.band_new = pwdata;
        cdb_pkg::REG_PSID: d.psid = pwdata;
        cdb_pkg::REG_CTRL: begin
          if (q.phase == H_IDLE && pwdata[1:0] != 2'h0) begin
            d.nbands  = pwdata[cdb_pkg::CTRL_NB_LSB +: 4];
            d.band    = '0;
            d.done    = 1'b0;
            d.err     = 1'b0;
            d.tamper  = 1'b0;
            d.inq_pos = '0;
            d.phase   = H_REQ;
            case (pwdata[1:0])
              cdb_pkg::CMD_PROV: d.step = cdb_pkg::STEP_PROV;
              cdb_pkg::CMD_ZERO: d.step = cdb_pkg::STEP_ZERO;
              default:           d.step = cdb_pkg::STEP_INQ;
            endcase
          end
        end
        default: d.psid = q.psid;
      endcase
    end
    case (q.phase)
      H_IDLE: d.band = d.band;
      H_REQ: begin
        if (lnk.req_ready) begin
          d.phase = H_RSP;
        end
      end
      H_RSP: begin
        if (lnk.rsp_valid) begin
          if (st.op == cdb_pkg::OP_INQ) begin
            d.inq_pos = q.inq_pos + 16'h0001;
            if (int'(q.inq_pos) < cdb_pkg::HDR_BYTES) begin
              d.inq_len = {q.inq_len[23:0], lnk.rsp_data[7:0]};
            end
            if (int'(q.inq_pos) == cdb_pkg::HDR_BYTES + cdb_pkg::OFF_STD) begin
              d.inq_std = lnk.rsp_data[7:0];
            end
            if (int'(q.inq_pos) == cdb_pkg::HDR_BYTES + cdb_pkg::OFF_LVL) begin
              d.inq_lvl = lnk.rsp_data[7:0];
            end
            if (lnk.rsp_last) begin
              d.done  = 1'b1;
              d.phase = H_IDLE;
            end
          end else if (!lnk.rsp_ok) begin
            d.err    = 1'b1;
            d.tamper = (st.op == cdb_pkg::OP_AUTH) && (st.auth != cdb_pkg::AU_PSID);
            d.phase  = H_IDLE;
          end else begin
            if (st.op == cdb_pkg::OP_GET_MSID) begin
              d.msid = lnk.rsp_data;
            end
            d.phase = H_REQ;
            if (q.step == cdb_pkg::STEP_PROV_END || q.step == cdb_pkg::STEP_ZERO_END) begin
              d.done  = 1'b1;
              d.phase = H_IDLE;
            end else if (q.step == cdb_pkg::STEP_EM_PIN && q.nbands == 4'h0) begin
              d.step = cdb_pkg::STEP_PROV_END;
            end else if (q.step == cdb_pkg::STEP_BAND_LAST && (q.band + 4'h1) < q.nbands) begin
              d.band = q.band + 4'h1;
              d.step = cdb_pkg::STEP_BAND_FIRST;
            end else begin
              d.step = q.step + 5'h01;
            end
          end
        end
      end
      default: d.phase = H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '{phase: H_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata       = q.prdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !addr_ok;
  assign lnk.req_valid = (q.phase == H_REQ);
  assign lnk.req_op    = st.op;
  assign lnk.req_auth  = st.auth;
  assign lnk.req_band  = q.band;
  assign lnk.rsp_ready = (q.phase == H_RSP);

  always_comb begin
    case (st.dsel)
      cdb_pkg::DS_MSID: lnk.req_data = q.msid;
      cdb_pkg::DS_SID:  lnk.req_data = q.sid_new;
      cdb_pkg::DS_EM:   lnk.req_data = q.em_new;
      cdb_pkg::DS_BAND: lnk.req_data = q.band_new;
      cdb_pkg::DS_PSID: lnk.req_data = q.psid;
      default:          lnk.req_data = 32'h0000_0000;
    endcase
  end
endmodule // cdb_host

// ===== tb/cdb_properties.sv
// cdb_properties: link checks of request answers and of the inquiry byte stream
`timescale 1ns/1ps
module cdb_properties (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             req_valid,
  input wire logic             req_ready,
  input wire cdb_pkg::cdb_op_t req_op,
  input wire logic             rsp_valid,
  input wire logic             rsp_ready,
  input wire logic             rsp_last,
  input wire logic [31:0]      rsp_data
);
  logic [9:0] cnt_q;
  logic       inq_q;
  logic [7:0] b;
  logic       bt;
  assign b  = rsp_data[7:0];
  assign bt = rsp_valid && inq_q;
  // beat counter of the current answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 10'h000;
      inq_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      cnt_q <= 10'h000;
      inq_q <= (req_op == cdb_pkg::OP_INQ);
    end else if (rsp_valid && rsp_ready) begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  a_rsp_next: assert property (s_take |=> rsp_valid && !req_ready) else $error("no answer");
  a_hdr_len: assert property (bt && cnt_q == 10'h003 |-> b == 8'h10) else $error("header");
  a_len_mid: assert property (bt && cnt_q inside {10'h002, 10'h00A} |-> b == 8'h02) else $error("len");
  a_desc_len: assert property (bt && cnt_q == 10'h00B |-> b == 8'h08) else $error("desc len");
  a_type_code: assert property (bt && cnt_q == 10'h005 |-> b == 8'h01) else $error("type");
  a_zero_bytes: assert property (bt && cnt_q inside {10'h000, 10'h001, 10'h004, 10'h006, 10'h007, 10'h008,
    10'h009, [10'h00E:10'h013]} |-> b == 8'h00) else $error("reserved");
  a_std_code: assert property (bt && cnt_q == 10'h00C |-> b inside {8'h32, 8'h33}) else $error("std");
  a_level_char: assert property (bt && cnt_q == 10'h00D |-> b inside {[8'h31:8'h34]}) else $error("lvl");
  a_str_null: assert property (bt && cnt_q inside {10'h093, 10'h213} |-> b == 8'h00) else $error("null end");
  a_last_beat: assert property (bt |-> rsp_last == (cnt_q == 10'h213)) else $error("last");
endmodule // cdb_properties

// ===== tb/compliance_descriptor_builder_tb.sv
// compliance_descriptor_builder_tb: APB driven bench of host and device
`timescale 1ns/1ps
module compliance_descriptor_builder_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        fips3_sel = 1'b0;
  logic [1:0]  level_sel = 2'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, e, makers_enabled, fw_port_locked, fw_lock_on_power;
  logic [1:0]  session;
  wire  [31:0] devst = {27'h0, makers_enabled, fw_port_locked, fw_lock_on_power, session};
  int          fail_count = 0;
  int          compares = 0;
  always #25 core_clk = ~core_clk;
  cdb_link_if lnk ();
  cdb_device cdb_device_i (.core_clk, .rst, .lnk(lnk), .fips3_sel, .level_sel, .makers_enabled, .fw_port_locked,
    .fw_lock_on_power, .session);
  cdb_host cdb_host_i (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .lnk(lnk));
  cdb_properties cdb_properties_i (.core_clk, .rst, .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
    .req_op(lnk.req_op), .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready), .rsp_last(lnk.rsp_last),
    .rsp_data(lnk.rsp_data));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) begin
      fail_count++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c, input logic [2:0] st, input string s);
    int k;
    k = 0;
    apb(1'b1, cdb_pkg::REG_CTRL, c);
    r = 32'h1;
    while (r[0] !== 1'b0 && k < 2000) begin
      k++;
      apb(1'b0, cdb_pkg::REG_STAT, 32'h0);
    end
    if (k == 2000) begin
      fail_count++;
      report_and_stop();
    end
    chk({29'h0, r[3:1]}, {29'h0, st});
    $display("test %s done", s);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(devst, 32'h10);
    for (int i = 0; i < 2; i++) begin
      fips3_sel <= i[0];
      level_sel <= {i[0], i[0]};
      run(32'h3, 3'b001, "inquiry");
      apb(1'b0, cdb_pkg::REG_INQLEN, 32'h0);
      chk(r, 32'h210);
      apb(1'b0, cdb_pkg::REG_INQINFO, 32'h0);
      chk(r, {16'h0214, i[0] ? 8'h34 : 8'h31, i[0] ? 8'h33 : 8'h32});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, cdb_pkg::REG_SID, 32'h1111_AAAA);
    apb(1'b1, cdb_pkg::REG_EM, 32'h2222_BBBB);
    apb(1'b1, cdb_pkg::REG_BAND, 32'h3333_CCCC);
    run(32'h0000_0201, 3'b001, "provision");
    chk(devst, 32'h0C);
    run(32'h0000_0201, 3'b110, "tamper");
    chk(devst, 32'h0D);
    apb(1'b1, cdb_pkg::REG_PSID, 32'h0);
    run(32'h2, 3'b010, "bad psid");
    apb(1'b1, cdb_pkg::REG_PSID, 32'h9ABC_0F0F);
    run(32'h2, 3'b001, "zeroize");
    chk(devst, 32'h10);
    run(32'h1, 3'b001, "reprovision");
    chk(devst, 32'h0C);
    report_and_stop();
  end
endmodule // compliance_descriptor_builder_tb
